// file: logic/egress_sched_pkg.sv
// constants and carrier types for the egress queue scheduler
// assumes one core clock of 10 MHz and a single AHB-Lite register slave
package egress_sched_pkg;

    // ------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------
    localparam int NPORT = 4;
    localparam int PW = 2;
    localparam int CW = 8;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // register map (byte addresses, low 12 bits decoded)
    // ------------------------------------------------------------
    localparam logic [11:0] THR_ADDR = 12'hf10;
    localparam logic [11:0] CTRL_ADDR = 12'hf14;
    localparam logic [11:0] CNT_ADDR = 12'hf18;
    localparam logic [11:0] STAT_ADDR = 12'hf1c;
    localparam int LOW_LSB = 0;
    localparam int HIGH_LSB = 16;
    localparam logic [7:0] LOW_RST = 8'h01;
    localparam logic [7:0] HIGH_RST = 8'h02;
    localparam int CTRL_SQ_BIT = 0;
    localparam logic CTRL_SQ_RST = 1'b0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int FWD_X4_NS = 118;
    localparam int FWD_X2_NS = 138;
    localparam int FWD_X1_NS = 188;
    localparam int CRD_OUT_NS = 212;
    localparam int ACK_OUT_NS = 88;
    localparam int CRD_IN_NS = 132;
    localparam int FWD_CYC = (FWD_X4_NS + CLK_NS - 1) / CLK_NS;
    localparam int CRD_OUT_CYC = (CRD_OUT_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACK_OUT_CYC = (ACK_OUT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CRD_IN_CYC = (CRD_IN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [CW-1:0] CRD_MAX = 8'hff;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PW-1:0] src;
        logic [PW-1:0] dst;
        logic [31:0] data;
    } pkt_t;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
    } ahb_req_t;

endpackage

// file: logic/desc_fifo.sv
// synchronous first-in first-out buffer with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/10ps
module desc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // full and empty come straight from the occupancy count
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage write
    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap at the depth
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
endmodule

// file: logic/egress_queue_scheduler.sv
// egress queuing and scheduling for a multi-port packet switch
// assumes one core clock, AHB-Lite register access and one-word packet descriptors
`timescale 1ns/10ps
module egress_queue_scheduler (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic in_valid,
    input wire egress_sched_pkg::pkt_t in_pkt,
    output logic [egress_sched_pkg::NPORT-1:0] in_ready,
    output logic out_valid,
    output egress_sched_pkg::pkt_t out_pkt,
    input wire logic out_ready,
    input wire logic credit_in,
    input wire logic ack_in,
    input wire logic [egress_sched_pkg::PW-1:0] ack_dst,
    output logic ack_out,
    output logic credit_out
);
    localparam int NP = egress_sched_pkg::NPORT;
    localparam int PW = egress_sched_pkg::PW;
    localparam int CW = egress_sched_pkg::CW;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    egress_sched_pkg::ahb_req_t dreq;
    logic dvalid;
    logic [7:0] high_wm;
    logic [7:0] low_wm;
    logic sq_en;
    logic [CW-1:0] cnt [NP];
    logic [NP-1:0] stop;
    logic [NP-1:0] hold_valid;
    logic addr_ok;
    logic [31:0] next_rdata;

    assign addr_ok = hsel && htrans[1] && hready;

    // read mux, sampled in the address phase
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (haddr[11:0])
            egress_sched_pkg::THR_ADDR: begin
                next_rdata[egress_sched_pkg::HIGH_LSB +: 8] = high_wm;
                next_rdata[egress_sched_pkg::LOW_LSB +: 8] = low_wm;
            end
            egress_sched_pkg::CTRL_ADDR: begin
                next_rdata[egress_sched_pkg::CTRL_SQ_BIT] = sq_en;
            end
            egress_sched_pkg::CNT_ADDR: begin
                next_rdata = {cnt[3], cnt[2], cnt[1], cnt[0]};
            end
            egress_sched_pkg::STAT_ADDR: begin
                next_rdata = {24'h00_0000, hold_valid, stop};
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // address phase capture and read data; zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dreq <= '0;
            dvalid <= 1'b0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dvalid <= addr_ok;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_ok) begin
                dreq.addr <= haddr[11:0];
                dreq.write <= hwrite;
                hrdata <= next_rdata;
            end
        end
    end

    // threshold and control writes; reserved bits are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_wm <= egress_sched_pkg::HIGH_RST;
            low_wm <= egress_sched_pkg::LOW_RST;
            sq_en <= egress_sched_pkg::CTRL_SQ_RST;
        end else if (dvalid && dreq.write) begin
            if (dreq.addr == egress_sched_pkg::THR_ADDR) begin
                high_wm <= hwdata[egress_sched_pkg::HIGH_LSB +: 8];
                low_wm <= hwdata[egress_sched_pkg::LOW_LSB +: 8];
            end
            if (dreq.addr == egress_sched_pkg::CTRL_ADDR) begin
                sq_en <= hwdata[egress_sched_pkg::CTRL_SQ_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // per-source queues
    // ------------------------------------------------------------
    egress_sched_pkg::pkt_t hold [NP];
    logic [1:0] rank [NP];
    logic acc;
    logic [NP-1:0] eligible;
    logic rel;
    logic [PW-1:0] rel_sel;
    logic fifo_in_ready;
    logic [2:0] nvalid;

    // index of the eligible entry that arrived first
    function automatic logic [PW-1:0] oldest(input logic [NP-1:0] el, input logic [1:0] rk [NP]);
        logic [PW-1:0] best;
        logic [1:0] brank;
        best = '0;
        brank = 2'h3;
        for (int i = 0; i < NP; i++) begin
            if (el[i] && rk[i] <= brank) begin
                best = PW'(i);
                brank = rk[i];
            end
        end
        return best;
    endfunction

    assign acc = in_valid && in_ready[in_pkt.src];

    // a held entry may leave while the destination queue has room and its destination is not stopped
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            eligible[i] = hold_valid[i] && !(sq_en && stop[hold[i].dst]) && fifo_in_ready;
        end
    end
    assign rel = |eligible;
    assign rel_sel = oldest(eligible, rank);

    always_comb begin
        nvalid = '0;
        for (int i = 0; i < NP; i++) begin
            nvalid = nvalid + {2'b00, hold_valid[i]};
        end
    end

    // entry contents
    always_ff @(posedge hclk) begin
        if (acc) begin
            hold[in_pkt.src] <= in_pkt;
        end
    end

    // occupancy, arrival rank and source ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_valid <= '0;
            in_ready <= '1;
            for (int i = 0; i < NP; i++) begin
                rank[i] <= 2'h0;
            end
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (rel && hold_valid[i] && rank[i] > rank[rel_sel]) begin
                    rank[i] <= rank[i] - 2'h1;
                end
                if (acc && in_pkt.src == PW'(i)) begin
                    hold_valid[i] <= 1'b1;
                    in_ready[i] <= 1'b0;
                    rank[i] <= nvalid[1:0] - {1'b0, rel};
                end else if (rel && rel_sel == PW'(i)) begin
                    hold_valid[i] <= 1'b0;
                    in_ready[i] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // destination queue and egress stage
    // ------------------------------------------------------------
    egress_sched_pkg::pkt_t fifo_head;
    logic fifo_out_valid;
    logic load;
    logic [CW-1:0] credits;
    logic [egress_sched_pkg::CRD_IN_CYC-1:0] crd_dly;
    logic stall;

    desc_fifo #(
        .WIDTH($bits(egress_sched_pkg::pkt_t)),
        .DEPTH(egress_sched_pkg::FIFO_DEPTH)
    ) u_dst_queue (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(rel),
        .in_ready(fifo_in_ready),
        .in_data(hold[rel_sel]),
        .out_valid(fifo_out_valid),
        .out_ready(load),
        .out_data(fifo_head)
    );

    assign stall = out_valid && !out_ready;
    assign load = fifo_out_valid && !stall && (credits != '0);

    // link credits arrive through a short delay before they can start a packet
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crd_dly <= '0;
            credits <= '0;
        end else begin
            crd_dly <= {crd_dly[egress_sched_pkg::CRD_IN_CYC-2:0], credit_in};
            if (crd_dly[egress_sched_pkg::CRD_IN_CYC-1] && !load && credits != egress_sched_pkg::CRD_MAX) begin
                credits <= credits + 1'b1;
            end else if (load && !crd_dly[egress_sched_pkg::CRD_IN_CYC-1]) begin
                credits <= credits - 1'b1;
            end
        end
    end

    // outgoing packet register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_valid <= 1'b0;
            out_pkt <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_pkt <= fifo_head;
        end else if (out_valid && out_ready) begin
            out_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // destination counts and watermarks
    // ------------------------------------------------------------
    // counted from queue entry until the partner acknowledges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NP; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (rel && hold[rel_sel].dst == PW'(i)) begin
                    if (!(ack_in && ack_dst == PW'(i) && cnt[i] != '0)) begin
                        cnt[i] <= cnt[i] + 1'b1;
                    end
                end else if (ack_in && ack_dst == PW'(i) && cnt[i] != '0) begin
                    cnt[i] <= cnt[i] - 1'b1;
                end
            end
        end
    end

    // stop at the high mark, resume below the low mark
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stop <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                stop[i] <= sq_en && (cnt[i] >= high_wm || (stop[i] && cnt[i] >= low_wm));
            end
        end
    end

    // ------------------------------------------------------------
    // link-layer replies
    // ------------------------------------------------------------
    logic ack_pend;
    logic [egress_sched_pkg::CRD_OUT_CYC-2:0] crd_out_dly;

    // acknowledge one cycle after packet end, deferred while egress is stalled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_out <= 1'b0;
            ack_pend <= 1'b0;
        end else begin
            ack_out <= (acc || ack_pend) && !stall;
            ack_pend <= (acc || ack_pend) && stall;
        end
    end

    // credit update three cycles after packet start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crd_out_dly <= '0;
            credit_out <= 1'b0;
        end else begin
            crd_out_dly <= {crd_out_dly[egress_sched_pkg::CRD_OUT_CYC-3:0], acc};
            credit_out <= crd_out_dly[egress_sched_pkg::CRD_OUT_CYC-2];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_stop_high;
        @(posedge hclk) disable iff (!hresetn) (sq_en && cnt[1] >= high_wm) |=> (stop[1] || !sq_en);
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("high mark did not stop port 1");

    property p_low_resume;
        @(posedge hclk) disable iff (!hresetn) (stop[1] && cnt[1] < low_wm) |=> !stop[1];
    endproperty
    a_low_resume: assert property (p_low_resume) else $error("port 1 not resumed below low mark");

    property p_no_fwd_stopped;
        @(posedge hclk) disable iff (!hresetn) (rel && sq_en) |-> !stop[hold[rel_sel].dst];
    endproperty
    a_no_fwd_stopped: assert property (p_no_fwd_stopped) else $error("packet sent to stopped port");

    property p_src_block;
        @(posedge hclk) disable iff (!hresetn) (hold_valid[1] && !eligible[1]) |=> !in_ready[1];
    endproperty
    a_src_block: assert property (p_src_block) else $error("blocked source 1 still ready");

    property p_ack_out;
        @(posedge hclk) disable iff (!hresetn) (acc && !stall) |=> ack_out;
    endproperty
    a_ack_out: assert property (p_ack_out) else $error("acknowledge late");

    property p_ack_hold;
        @(posedge hclk) disable iff (!hresetn) stall |=> !ack_out;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("acknowledge sent during stall");

    property p_credit_out;
        @(posedge hclk) disable iff (!hresetn) acc |-> ##3 credit_out;
    endproperty
    a_credit_out: assert property (p_credit_out) else $error("credit update not three cycles after start");

    property p_cnt_ack;
        @(posedge hclk) disable iff (!hresetn)
            (ack_in && ack_dst == 2'h0 && cnt[0] != 8'h00 && !(rel && hold[rel_sel].dst == 2'h0))
            |=> cnt[0] == $past(cnt[0]) - 8'h01;
    endproperty
    a_cnt_ack: assert property (p_cnt_ack) else $error("count not released on acknowledge");

    property p_default_fifo;
        @(posedge hclk) disable iff (!hresetn) !sq_en |=> (stop == 4'h0 || sq_en);
    endproperty
    a_default_fifo: assert property (p_default_fifo) else $error("stop set without source queuing");

    property p_fwd;
        @(posedge hclk) disable iff (!hresetn)
            (acc && !sq_en && hold_valid == 4'h0 && !fifo_out_valid && !out_valid && credits > 8'h01)
            |-> ##3 out_valid;
    endproperty
    a_fwd: assert property (p_fwd) else $error("cut-through start not three cycles after arrival");
endmodule

// file: test/link_partner.sv
// link partner model on the egress side of the scheduler
// assumes the bench drives the slow, credit and ack-hold controls
`timescale 1ns/10ps
module link_partner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic out_valid,
    input wire egress_sched_pkg::pkt_t out_pkt,
    input wire logic slow,
    input wire logic credit_en,
    input wire logic hold_ack,
    output logic out_ready,
    output logic credit_in,
    output logic ack_in,
    output logic [egress_sched_pkg::PW-1:0] ack_dst
);
    // ------------------------------------------------------------
    // receive, grant credit, acknowledge
    // ------------------------------------------------------------
    logic [3:0] tick;
    logic [egress_sched_pkg::PW-1:0] pend[$];

    // slow mode takes one packet in four cycles; acks wait while held
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick <= 4'h0;
            out_ready <= 1'b0;
            credit_in <= 1'b0;
            ack_in <= 1'b0;
            ack_dst <= 2'h0;
            pend.delete();
        end else begin
            tick <= tick + 4'h1;
            out_ready <= !slow || tick[1:0] == 2'h3;
            credit_in <= credit_en && tick[0];
            if (out_valid && out_ready) begin
                pend.push_back(out_pkt.dst);
            end
            if (!hold_ack && pend.size() > 0) begin
                ack_in <= 1'b1;
                ack_dst <= pend.pop_front();
            end else begin
                ack_in <= 1'b0;
                ack_dst <= ~ack_dst; // no stale value between acks
            end
        end
    end
endmodule

// file: test/switch_egress_queue_scheduler_tb_top.sv
// self-checking bench for the egress queue scheduler
// assumes link_partner on the egress side; the bench drives ingress and bus
`timescale 1ns/10ps
module switch_egress_queue_scheduler_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, out_valid, out_ready, credit_in, ack_in, ack_out, credit_out;
    logic [31:0] hrdata, rd;
    logic in_valid = 1'b0;
    egress_sched_pkg::pkt_t in_pkt = '0;
    egress_sched_pkg::pkt_t out_pkt;
    logic [3:0] in_ready;
    logic [1:0] ack_dst;
    logic slow = 1'b0;
    logic credit_en = 1'b0;
    logic hold_ack = 1'b1;
    logic [35:0] sent[$], got[$];
    int num_errors = 0, n_checks = 0, n_crd = 0;

    egress_queue_scheduler dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid), .in_pkt(in_pkt), .in_ready(in_ready),
        .out_valid(out_valid), .out_pkt(out_pkt), .out_ready(out_ready), .credit_in(credit_in),
        .ack_in(ack_in), .ack_dst(ack_dst), .ack_out(ack_out), .credit_out(credit_out));
    link_partner peer (.hclk(hclk), .hresetn(hresetn), .out_valid(out_valid), .out_pkt(out_pkt),
        .slow(slow), .credit_en(credit_en), .hold_ack(hold_ack), .out_ready(out_ready),
        .credit_in(credit_in), .ack_in(ack_in), .ack_dst(ack_dst));

    // ------------------------------------------------------------
    // clock, monitor and shared tasks
    // ------------------------------------------------------------
    always #50 hclk = ~hclk;

    // record every egress handshake and credit update pulse
    always @(posedge hclk) begin
        if (hresetn && out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_pkt);
        if (credit_out === 1'b1) n_crd++;
    end

    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wait_ready();
        int n;
        for (n = 0; n < 99; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (n >= 99) num_errors++;
    endtask

    // one single word transfer: address phase, then data phase
    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d);
        @(posedge hclk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        ahb(a, 1'b0, 32'h0);
        chk({hresp, rd}, {1'b0, e});
    endtask

    // offer one descriptor; ok tells whether it was taken
    task automatic send(input logic [1:0] s, input logic [1:0] d, input logic [31:0] v, output bit ok);
        int n;
        ok = 0;
        if (in_valid) @(posedge hclk); // let an edge pass between two offers
        in_pkt <= {s, d, v};
        in_valid <= 1'b1;
        for (n = 0; n < 12 && !ok; n++) begin
            @(posedge hclk);
            ok = in_ready[s] === 1'b1;
        end
        in_valid <= 1'b0;
        if (ok) sent.push_back({s, d, v});
    endtask

    task automatic wait_got(input int n);
        int i;
        for (i = 0; i < 400 && got.size() < n; i++) @(posedge hclk);
    endtask

    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rdc(12'hf10, 32'h0002_0001);
        rdc(12'hf14, 32'h0);
        rdc(12'hf18, 32'h0);
        wr(12'hf10, 32'hffff_ffff);
        rdc(12'hf10, 32'h00ff_00ff);
        wr(12'hf20, 32'hffff_ffff);
        rdc(12'hf20, 32'h0);
        wr(12'hf10, 32'h0002_0001);
        rdc(12'hf10, 32'h0002_0001);
    endtask

    // fill the queue with no credit, then drain it past a stalling partner
    task automatic t_fifo();
        int i, k;
        bit ok;
        logic [31:0] c;
        c = 32'h0;
        k = 0;
        ok = 1;
        for (i = 0; i < 24 && ok; i++) begin
            send(i[1:0], i[3:2], 32'ha000_0000 + i, ok);
            if (ok) begin
                k++;
                if (i < egress_sched_pkg::FIFO_DEPTH) c += 32'h1 << (8 * i[3:2]); // held entries not yet queued
            end
        end
        chk(k, egress_sched_pkg::FIFO_DEPTH + egress_sched_pkg::NPORT);
        rdc(12'hf18, c);
        slow <= 1'b1;
        credit_en <= 1'b1;
        wait_got(k);
        chk(got.size(), k);
        for (i = 0; i < k; i++) chk(got[i], sent[i]);
        hold_ack <= 1'b0;
        repeat (40) @(posedge hclk);
        rdc(12'hf18, 32'h0);
        chk(n_crd, k);
        sent.delete();
        got.delete();
    endtask

    // forward delay, acknowledge and credit update of a lone packet
    task automatic t_lat();
        bit ok;
        slow <= 1'b0;
        repeat (4) @(posedge hclk);
        send(2'h1, 2'h2, 32'h5a5a_0001, ok);
        #1;
        chk({ack_out, out_valid}, 2'b10);
        @(posedge hclk);
        #1;
        chk(out_valid, 1'b0);
        @(posedge hclk);
        #1;
        chk(out_valid, 1'b1);
        chk(credit_out, 1'b1);
        wait_got(1);
        chk(got.pop_front(), sent.pop_front());
    endtask

    // saturate destination 1 and watch source 2 block, then release
    task automatic t_srcq();
        int i;
        int m[5] = '{0, 1, 3, 2, 4};
        bit ok;
        hold_ack <= 1'b1;
        wr(12'hf14, 32'h1);
        send(2'h0, 2'h1, 32'hb0, ok);
        send(2'h0, 2'h1, 32'hb1, ok);
        repeat (4) @(posedge hclk);
        send(2'h2, 2'h1, 32'hb2, ok);
        repeat (4) @(posedge hclk);
        chk(in_ready[2], 1'b0);
        rdc(12'hf1c, 32'h0000_0042);
        send(2'h2, 2'h0, 32'hb3, ok);
        chk(ok, 1'b0);
        send(2'h3, 2'h0, 32'hb4, ok);
        wait_got(3);
        repeat (6) @(posedge hclk);
        chk(got.size(), 3);
        hold_ack <= 1'b0;
        wait_got(4);
        send(2'h2, 2'h0, 32'hb3, ok);
        wait_got(5);
        chk(got.size(), 5);
        for (i = 0; i < 5; i++) chk(got[i], sent[m[i]]);
    endtask

    // main sequence after a reset of eight cycles
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_fifo();
        t_lat();
        t_srcq();
        complete_run();
    end

    // cut a hang short well beyond the expected run length
    initial begin
        repeat (6000) @(posedge hclk);
        num_errors++;
        complete_run();
    end
endmodule
